//--- logic/line_event_cfg.svh
// offsets, reset values and line layout of the event line controller
// assumes a 32-bit apb slave port with byte addresses
//
// Notes on behaviour
// - 29 lines: 23 external, 6 internal
// - external edges selectable; internal rising only
// - separate interrupt and event masks per line
// - internal lines act only in stop mode
// - selected edge with irq mask sets pending
// - writing one to pending clears it
// - internal irq masks reset enabled, no pending
// - event mask gives pulse, never sets pending
// - event output is a single-cycle pulse
// - drive event, interrupt and wake-up requests
// - soft trigger register acts on external lines
// - soft trigger merged with hardware edge source
// - lines 0 to 15 from selected pins
// - lines 16 to 22 from supply monitor, clock, usb wake, tamper, comparators
// - lines 23 to 28 internal wake-up lines
// - rising and falling both enabled trigger either
// - edge during a write to its own select register sets no pending
// - soft trigger reads one until pending cleared
`ifndef LINE_EVENT_CFG_SVH
`define LINE_EVENT_CFG_SVH

`define LINE_NUM_ALL 29
`define LINE_NUM_EXT 23
`define LINE_NUM_INT 6

`define LINE_OFF_IMR 8'h00
`define LINE_OFF_EMR 8'h04
`define LINE_OFF_RTSR 8'h08
`define LINE_OFF_FTSR 8'h0C
`define LINE_OFF_SWIER 8'h10
`define LINE_OFF_PR 8'h14

`define LINE_IMR_RST 29'h1F80_0000
`define LINE_EMR_RST 29'h0000_0000
`define LINE_EXT_RST 23'h00_0000

`endif

//--- logic/line_event_pkg.sv
// types shared by the event line controller
// assumes line numbering 0..22 external, 23..28 internal
package line_event_pkg;

    typedef logic [28:0] line_vec_t;
    typedef logic [22:0] ext_vec_t;
    typedef logic [5:0] int_vec_t;

    // msb first, so the packed value is the line vector 22..0
    typedef struct packed {
        logic comp2;
        logic comp1;
        logic clk_wake;
        logic tamper_ts;
        logic usb_wake;
        logic clk_alarm;
        logic supply_voltage_monitor;
        logic [15:0] pin_line;
    } ext_src_s;

    // asynchronous wake versions, lines 28..23
    typedef struct packed {
        logic serial3_wake;
        logic consumer_ctrl_link_wake;
        logic serial2_wake;
        logic serial1_wake;
        logic i2c2_wake;
        logic i2c1_wake;
    } int_src_s;

endpackage : line_event_pkg

//--- logic/line_event_controller.sv
// event and interrupt line controller with apb register port
// assumes pin selection is done outside; stop_mode comes on clk
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "line_event_cfg.svh"

module line_event_controller #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire line_event_pkg::ext_src_s ext_src,
    input wire line_event_pkg::int_src_s int_src,
    input wire logic stop_mode,
    output line_event_pkg::line_vec_t irq_req,
    output logic event_pulse,
    output logic wake_req
);
    import line_event_pkg::*;

    function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == ADDR_W'(off);
    endfunction : at

    // synchronisers and previous samples
    ext_vec_t ext_s1_q, ext_s1_d, ext_s2_q, ext_s2_d, ext_prev_q, ext_prev_d;
    int_vec_t int_s1_q, int_s1_d, int_s2_q, int_s2_d, int_prev_q, int_prev_d;

    always_comb begin : sync_next
        ext_s1_d = ext_vec_t'(ext_src);
        ext_s2_d = ext_s1_q;
        ext_prev_d = ext_s2_q;
        int_s1_d = int_vec_t'(int_src);
        int_s2_d = int_s1_q;
        int_prev_d = int_s2_q;
    end

    always_ff @(posedge clk) begin : sync_regs
        if (!nrst) begin
            ext_s1_q <= `LINE_EXT_RST;
            ext_s2_q <= `LINE_EXT_RST;
            ext_prev_q <= `LINE_EXT_RST;
            int_s1_q <= '0;
            int_s2_q <= '0;
            int_prev_q <= '0;
        end else if (ce) begin
            ext_s1_q <= ext_s1_d;
            ext_s2_q <= ext_s2_d;
            ext_prev_q <= ext_prev_d;
            int_s1_q <= int_s1_d;
            int_s2_q <= int_s2_d;
            int_prev_q <= int_prev_d;
        end
    end

    // apb slave: one wait state, answer from flops
    logic pready_q, pready_d, slverr_q, slverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic acc, wr, mapped;
    logic wr_imr, wr_emr, wr_rtsr, wr_ftsr, wr_swier, wr_pr;

    line_vec_t imr_q, imr_d, emr_q, emr_d;
    ext_vec_t rtsr_q, rtsr_d, ftsr_q, ftsr_d;
    ext_vec_t swier_q, swier_d, pend_q, pend_d;

    always_comb begin : bus_decode
        acc = psel & penable & pready_q;
        wr = acc & pwrite;
        mapped = at(paddr, `LINE_OFF_IMR) | at(paddr, `LINE_OFF_EMR)
            | at(paddr, `LINE_OFF_RTSR) | at(paddr, `LINE_OFF_FTSR)
            | at(paddr, `LINE_OFF_SWIER) | at(paddr, `LINE_OFF_PR);
        wr_imr = wr & at(paddr, `LINE_OFF_IMR);
        wr_emr = wr & at(paddr, `LINE_OFF_EMR);
        wr_rtsr = wr & at(paddr, `LINE_OFF_RTSR);
        wr_ftsr = wr & at(paddr, `LINE_OFF_FTSR);
        wr_swier = wr & at(paddr, `LINE_OFF_SWIER);
        wr_pr = wr & at(paddr, `LINE_OFF_PR);
    end

    always_comb begin : bus_next
        pready_d = psel & penable & ~pready_q;
        slverr_d = 1'b0;
        prdata_d = prdata_q;
        if (psel & penable & ~pready_q) begin
            slverr_d = ~mapped;
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
                if (at(paddr, `LINE_OFF_IMR)) begin
                    prdata_d = {3'h0, imr_q};
                end
                if (at(paddr, `LINE_OFF_EMR)) begin
                    prdata_d = {3'h0, emr_q};
                end
                if (at(paddr, `LINE_OFF_RTSR)) begin
                    prdata_d = {9'h000, rtsr_q};
                end
                if (at(paddr, `LINE_OFF_FTSR)) begin
                    prdata_d = {9'h000, ftsr_q};
                end
                if (at(paddr, `LINE_OFF_SWIER)) begin
                    prdata_d = {9'h000, swier_q};
                end
                if (at(paddr, `LINE_OFF_PR)) begin
                    prdata_d = {9'h000, pend_q};
                end
            end
        end
    end

    always_ff @(posedge clk) begin : bus_regs
        if (!nrst) begin
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= pready_d;
            slverr_q <= slverr_d;
            prdata_q <= prdata_d;
        end
    end

    // edge detection, triggers and flags
    ext_vec_t rise_raw, fall_raw, rise_hit, fall_hit, sw_trig, trig_ext, pr_clr;
    int_vec_t int_rise;
    line_vec_t irq_d, irq_q;
    logic ev_d, ev_q, wake_d, wake_q;

    always_comb begin : line_next
        rise_raw = ext_s2_q & ~ext_prev_q;
        fall_raw = ~ext_s2_q & ext_prev_q;
        // a write to a select register masks that edge kind this cycle
        rise_hit = rise_raw & rtsr_q & {23{~wr_rtsr}};
        fall_hit = fall_raw & ftsr_q & {23{~wr_ftsr}};
        sw_trig = wr_swier ? (pwdata[22:0] & ~swier_q) : '0;
        trig_ext = rise_hit | fall_hit | sw_trig;
        pr_clr = wr_pr ? pwdata[22:0] : '0;
        // internal lines: rising only, and only in stop mode
        int_rise = int_s2_q & ~int_prev_q & {6{stop_mode}};
        imr_d = wr_imr ? pwdata[28:0] : imr_q;
        emr_d = wr_emr ? pwdata[28:0] : emr_q;
        rtsr_d = wr_rtsr ? pwdata[22:0] : rtsr_q;
        ftsr_d = wr_ftsr ? pwdata[22:0] : ftsr_q;
        // set wins over a clear in the same cycle
        pend_d = (pend_q & ~pr_clr) | (trig_ext & imr_q[22:0]);
        swier_d = (swier_q & ~pr_clr) | sw_trig;
        irq_d = {int_rise & imr_q[28:23], pend_d & imr_d[22:0]};
        ev_d = |(trig_ext & emr_q[22:0]) | |(int_rise & emr_q[28:23]);
        wake_d = |irq_d | ev_d;
    end

    always_ff @(posedge clk) begin : line_regs
        if (!nrst) begin
            imr_q <= `LINE_IMR_RST;
            emr_q <= `LINE_EMR_RST;
            rtsr_q <= `LINE_EXT_RST;
            ftsr_q <= `LINE_EXT_RST;
            swier_q <= `LINE_EXT_RST;
            pend_q <= `LINE_EXT_RST;
            irq_q <= '0;
            ev_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (ce) begin
            imr_q <= imr_d;
            emr_q <= emr_d;
            rtsr_q <= rtsr_d;
            ftsr_q <= ftsr_d;
            swier_q <= swier_d;
            pend_q <= pend_d;
            irq_q <= irq_d;
            ev_q <= ev_d;
            wake_q <= wake_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = slverr_q;
    assign irq_req = irq_q;
    assign event_pulse = ev_q;
    assign wake_req = wake_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    chk_bus_answer: assert property (
        ce && psel && penable && !pready_q |=> pready_q ##1 !pready_q || !ce)
        else $error("apb answer not one wait state");

    chk_pend_set: assert property (
        ce && |(trig_ext & imr_q[22:0])
        |=> (pend_q & $past(trig_ext & imr_q[22:0])) == $past(trig_ext & imr_q[22:0]))
        else $error("masked-in trigger did not set pending");

    chk_pend_clear: assert property (
        ce && wr_pr && (pr_clr & trig_ext) == '0 && |pr_clr
        |=> (pend_q & $past(pr_clr)) == '0 && (irq_q[22:0] & $past(pr_clr)) == '0)
        else $error("pending or request survived clear");

    chk_event_no_pend: assert property (
        ce && (trig_ext & imr_q[22:0]) == '0
        |=> (pend_q & ~$past(pend_q)) == '0)
        else $error("event-only trigger set pending");

    chk_event_fires: assert property (
        ce && (|(trig_ext & emr_q[22:0]) || |(int_rise & emr_q[28:23])) |=> event_pulse)
        else $error("enabled edge gave no event pulse");

    chk_int_running: assert property (
        ce && !stop_mode |=> irq_q[28:23] == '0)
        else $error("internal line acted outside stop mode");

    chk_soft_trigger: assert property (
        ce && wr_swier && |(sw_trig & imr_q[22:0])
        |=> (swier_q & pend_q & $past(sw_trig & imr_q[22:0]))
            == $past(sw_trig & imr_q[22:0]))
        else $error("soft trigger did not set flag and pending");

    chk_soft_clear: assert property (
        ce && wr_pr && !wr_swier |=> (swier_q & $past(pr_clr)) == '0)
        else $error("soft trigger bit not cleared with pending");

    chk_rise_block: assert property (
        ce && wr_rtsr && (fall_hit | sw_trig) == '0
        |=> (pend_q & ~$past(pend_q)) == '0)
        else $error("edge during select write set pending");

    chk_wake_follow: assert property (
        ce && (ev_d || |irq_d) |=> wake_req)
        else $error("wake-up request missing");

endmodule : line_event_controller

//--- sim/core_power_model.sv
// model of core event input and power manager beside the controller
// assumes stop_req from the bench and wake_req on the same clock
`timescale 1ns/1ps

module core_power_model (
    input wire logic clk,
    input wire logic nrst,
    input wire line_event_pkg::line_vec_t irq_req,
    input wire logic event_pulse,
    input wire logic wake_req,
    input wire logic stop_req,
    output logic stop_mode,
    output line_event_pkg::line_vec_t irq_seen,
    output logic [7:0] ev_count
);
    import line_event_pkg::*;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stop_mode <= 1'b0;
            irq_seen <= '0;
            ev_count <= 8'h00;
        end else begin
            // leaves stop on any wake request
            if (wake_req) begin
                stop_mode <= 1'b0;
            end else if (stop_req) begin
                stop_mode <= 1'b1;
            end
            irq_seen <= irq_seen | irq_req;
            if (event_pulse) begin
                ev_count <= ev_count + 8'h01;
            end
        end
    end
endmodule : core_power_model

//--- sim/testbench.sv
// self-checking bench for the event line controller
// assumes the core and power manager model beside the design
`timescale 1ns/1ps
`include "line_event_cfg.svh"

module testbench;
    import line_event_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ext_src_s ext_src = '0;
    int_src_s int_src = '0;
    logic stop_req = 1'b0;
    logic stop_mode;
    line_vec_t irq_req;
    line_vec_t irq_seen;
    logic event_pulse;
    logic wake_req;
    logic [7:0] ev_count;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    line_event_controller i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_src(ext_src),
        .int_src(int_src), .stop_mode(stop_mode), .irq_req(irq_req),
        .event_pulse(event_pulse), .wake_req(wake_req));

    core_power_model i_core (.clk(clk), .nrst(nrst), .irq_req(irq_req),
        .event_pulse(event_pulse), .wake_req(wake_req), .stop_req(stop_req),
        .stop_mode(stop_mode), .irq_seen(irq_seen), .ev_count(ev_count));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask : ticks

    // one apb transfer, entered right after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic t_reset_map;
        apb(0, `LINE_OFF_IMR, 0);
        chk("irq mask reset", 32'h1F80_0000, rd);
        apb(0, `LINE_OFF_EMR, 0);
        chk("event mask reset", 32'h0000_0000, rd);
        apb(0, 8'h18, 0);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        apb(0, `LINE_OFF_PR, 0);
        chk("pending reset", 32'h0000_0000, rd);
    endtask : t_reset_map

    task automatic t_pin_irq;
        apb(1, `LINE_OFF_RTSR, 32'h0000_0001);
        apb(1, `LINE_OFF_IMR, 32'h1F80_0001);
        ext_src.pin_line[0] <= 1'b1;
        ticks(5);
        chk("pin irq", 32'h0000_0001, {31'h0, irq_req[0]});
        apb(0, `LINE_OFF_PR, 0);
        chk("pin pending", 32'h0000_0001, rd);
        apb(1, `LINE_OFF_PR, 32'h0000_0001);
        apb(0, `LINE_OFF_PR, 0);
        chk("pin cleared", 32'h0000_0000, rd);
        chk("pin irq off", 32'h0000_0000, {31'h0, irq_req[0]});
        ext_src.pin_line[0] <= 1'b0;
        ticks(5);
        apb(0, `LINE_OFF_PR, 0);
        chk("falling ignored", 32'h0000_0000, rd);
    endtask : t_pin_irq

    task automatic t_event_edges;
        logic [7:0] c0;
        c0 = ev_count;
        apb(1, `LINE_OFF_FTSR, 32'h0001_0000);
        apb(1, `LINE_OFF_RTSR, 32'h0001_0000);
        apb(1, `LINE_OFF_EMR, 32'h0001_0000);
        ext_src.supply_voltage_monitor <= 1'b1;
        ticks(8);
        ext_src.supply_voltage_monitor <= 1'b0;
        ticks(8);
        chk("event pulses", {24'h0, c0 + 8'h02}, {24'h0, ev_count});
        apb(0, `LINE_OFF_PR, 0);
        chk("event no pending", 32'h0000_0000, rd);
        apb(1, `LINE_OFF_EMR, 32'h0000_0000);
    endtask : t_event_edges

    task automatic t_soft;
        apb(1, `LINE_OFF_IMR, 32'h1FC0_0000);
        apb(1, `LINE_OFF_SWIER, 32'h0040_0000);
        ticks(1);
        chk("soft irq", 32'h0000_0001, {31'h0, irq_req[22]});
        apb(0, `LINE_OFF_SWIER, 0);
        chk("soft readback", 32'h0040_0000, rd);
        apb(0, `LINE_OFF_PR, 0);
        chk("soft pending", 32'h0040_0000, rd);
        apb(1, `LINE_OFF_PR, 32'h0040_0000);
        apb(0, `LINE_OFF_SWIER, 0);
        chk("soft auto clear", 32'h0000_0000, rd);
    endtask : t_soft

    task automatic t_select_race;
        apb(1, `LINE_OFF_IMR, 32'h1F80_0002);
        apb(1, `LINE_OFF_RTSR, 32'h0001_0003);
        // edge reaches the detector in the cycle the rewrite completes
        ext_src.pin_line[1] <= 1'b1;
        apb(1, `LINE_OFF_RTSR, 32'h0001_0003);
        ticks(3);
        apb(0, `LINE_OFF_PR, 0);
        chk("edge during select write", 32'h0000_0000, rd);
        ext_src.pin_line[1] <= 1'b0;
        ticks(5);
        ext_src.pin_line[1] <= 1'b1;
        ticks(5);
        apb(0, `LINE_OFF_PR, 0);
        chk("edge after select write", 32'h0000_0002, rd);
        apb(1, `LINE_OFF_PR, 32'h0000_0002);
    endtask : t_select_race

    task automatic t_internal;
        int_src.i2c1_wake <= 1'b1;
        ticks(6);
        chk("internal in run", 32'h0000_0000, {31'h0, irq_seen[23]});
        int_src.i2c1_wake <= 1'b0;
        stop_req <= 1'b1;
        ticks(6);
        stop_req <= 1'b0;
        chk("stop entered", 32'h0000_0001, {31'h0, stop_mode});
        int_src.i2c1_wake <= 1'b1;
        ticks(6);
        chk("internal in stop", 32'h0000_0001, {31'h0, irq_seen[23]});
        chk("woken", 32'h0000_0000, {31'h0, stop_mode});
        apb(0, `LINE_OFF_PR, 0);
        chk("no internal pending", 32'h0000_0000, rd);
    endtask : t_internal

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset_map();
        t_pin_irq();
        t_event_edges();
        t_soft();
        t_select_race();
        t_internal();
        end_sim();
    end
endmodule : testbench
